//--- core/led_i2c_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - sda falling while scl high marks a start and opens a frame
// - sda rising while scl high marks a stop and ends the frame
// - repeated start behaves exactly like start, address reception restarts
// - bus counts busy from start until stop, idle afterwards
// - sda changes only while scl is low, except start and stop
// - bytes are eight bits, msb first, then one acknowledge bit
// - any number of bytes may follow within one frame
// - when addressed as receiver, every byte is acknowledged by pulling sda low
// - slave address is 1110 followed by the three strap bits
// - eighth address bit is direction: one reads, zero writes
// - acknowledge only on address match, otherwise ignore the frame
// - strap inputs are sampled again at every frame start
// - single write: address, command byte, one data byte, stop
// - byte after address loads pointer; pointer steps on each data ack clock
// - display pointer wraps from 0x0f back to 0x00
// - single read: write address, pointer, repeated start, read, nack, stop
// - in reads the pointer steps only on master acknowledge
// - read bytes keep coming until not-acknowledge and stop
// - key data pointer wraps from 0x45 back to 0x40
// - writes aimed at 0x40 through 0x45 are dropped
// - reading key data to its end pulses the key memory clear
module led_i2c_slave_port #(
    parameter int FIFO_DEPTH = led_i2c_pkg::WR_FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       addr_strap_bit2,
    input  wire logic       addr_strap_bit1,
    input  wire logic       addr_strap_bit0,
    input  wire logic [7:0] rd_data,
    output logic      [7:0] register_pointer_value,
    output logic            bus_busy,
    output logic            key_read_done,
    output logic            wr_valid,
    input  wire logic       wr_ready,
    output logic            wr_cmd,
    output logic      [7:0] wr_addr,
    output logic      [7:0] wr_data
);
    // ------------------------------------------------------------
    // pin synchronisers and bus conditions
    // ------------------------------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic [2:0] strap_meta_ff;
    logic [2:0] strap_sync_ff;
    logic       scl_q_ff;
    logic       sda_q_ff;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;

    // two flops on every pin; stage two is looked at, plus a delayed copy of it for scl and sda
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_sync_ff   <= 2'h3;
            sda_sync_ff   <= 2'h3;
            strap_meta_ff <= 3'h0;
            strap_sync_ff <= 3'h0;
            scl_q_ff      <= 1'b1;
            sda_q_ff      <= 1'b1;
        end else begin
            scl_sync_ff   <= {scl_sync_ff[0], scl_i};
            sda_sync_ff   <= {sda_sync_ff[0], sda_i};
            strap_meta_ff <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_sync_ff <= strap_meta_ff;
            scl_q_ff      <= scl_sync_ff[1];
            sda_q_ff      <= sda_sync_ff[1];
        end
    end

    assign scl_s    = scl_sync_ff[1];
    assign sda_s    = sda_sync_ff[1];
    assign scl_rise = scl_s & ~scl_q_ff;
    assign scl_fall = ~scl_s & scl_q_ff;
    // conditions need scl high on both samples, so a data change never looks like one
    assign start_ev = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign stop_ev  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    led_i2c_pkg::port_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic       ack_phase_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic       sda_oe_ff;
    logic [7:0] ptr_ff;
    logic [2:0] my_strap_ff;
    logic       busy_ff;
    logic       key_done_ff;
    logic       rx_state;
    logic       byte_end;
    logic       addr_match;

    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        if (p == led_i2c_pkg::DISP_LAST) begin
            return led_i2c_pkg::DISP_FIRST;
        end else if (p == led_i2c_pkg::KEY_LAST) begin
            return led_i2c_pkg::KEY_FIRST;
        end else begin
            return p + 8'h01;
        end
    endfunction : next_ptr

    function automatic logic is_key(input logic [7:0] p);
        return (p >= led_i2c_pkg::KEY_FIRST) && (p <= led_i2c_pkg::KEY_LAST);
    endfunction : is_key

    assign rx_state   = (state_ff == led_i2c_pkg::ST_ADDR) ||
                        (state_ff == led_i2c_pkg::ST_CMD) ||
                        (state_ff == led_i2c_pkg::ST_WDATA);
    assign byte_end   = scl_fall & ~ack_phase_ff & (bit_cnt_ff == led_i2c_pkg::BYTE_BITS);
    assign addr_match = (shift_ff[7:1] == {led_i2c_pkg::ADDR_FIXED, my_strap_ff});

    // one process for the frame: start and stop override any bit activity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff     <= led_i2c_pkg::ST_IDLE;
            bit_cnt_ff   <= 4'h0;
            ack_phase_ff <= 1'b0;
            shift_ff     <= 8'h00;
            tx_ff        <= 8'h00;
            sda_oe_ff    <= 1'b0;
            ptr_ff       <= led_i2c_pkg::PTR_RESET;
            my_strap_ff  <= 3'h0;
            busy_ff      <= 1'b0;
            key_done_ff  <= 1'b0;
        end else begin
            key_done_ff <= 1'b0;
            if (start_ev) begin
                state_ff     <= led_i2c_pkg::ST_ADDR;
                busy_ff      <= 1'b1;
                my_strap_ff  <= strap_sync_ff;
                bit_cnt_ff   <= 4'h0;
                ack_phase_ff <= 1'b0;
                sda_oe_ff    <= 1'b0;
            end else if (stop_ev) begin
                state_ff     <= led_i2c_pkg::ST_IDLE;
                busy_ff      <= 1'b0;
                ack_phase_ff <= 1'b0;
                sda_oe_ff    <= 1'b0;
            end else if (scl_rise) begin
                if (!ack_phase_ff && rx_state) begin
                    shift_ff   <= {shift_ff[6:0], sda_s};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end else if (ack_phase_ff) begin
                    if (state_ff == led_i2c_pkg::ST_CMD) begin
                        ptr_ff <= shift_ff;
                    end else if (state_ff == led_i2c_pkg::ST_WDATA) begin
                        ptr_ff <= next_ptr(ptr_ff);
                    end else if (state_ff == led_i2c_pkg::ST_RDATA) begin
                        key_done_ff <= (ptr_ff == led_i2c_pkg::KEY_LAST);
                        if (!sda_s) begin
                            ptr_ff <= next_ptr(ptr_ff);
                        end else begin
                            state_ff <= led_i2c_pkg::ST_IGNORE;
                        end
                    end
                end
            end else if (scl_fall) begin
                if (byte_end && state_ff != led_i2c_pkg::ST_IDLE &&
                    state_ff != led_i2c_pkg::ST_IGNORE) begin
                    ack_phase_ff <= 1'b1;
                    if (state_ff == led_i2c_pkg::ST_ADDR) begin
                        if (addr_match) begin
                            sda_oe_ff <= 1'b1;
                        end else begin
                            state_ff <= led_i2c_pkg::ST_IGNORE;
                        end
                    end else if (state_ff == led_i2c_pkg::ST_RDATA) begin
                        sda_oe_ff <= 1'b0;
                    end else begin
                        sda_oe_ff <= 1'b1;
                    end
                end else if (ack_phase_ff) begin
                    ack_phase_ff <= 1'b0;
                    if (state_ff == led_i2c_pkg::ST_IGNORE) begin
                        sda_oe_ff <= 1'b0;
                    end else if ((state_ff == led_i2c_pkg::ST_ADDR && shift_ff[0]) ||
                                 state_ff == led_i2c_pkg::ST_RDATA) begin
                        // pointer settled long ago, so rd_data is valid here
                        state_ff   <= led_i2c_pkg::ST_RDATA;
                        tx_ff      <= {rd_data[6:0], 1'b0};
                        sda_oe_ff  <= ~rd_data[7];
                        bit_cnt_ff <= 4'h1;
                    end else begin
                        state_ff   <= (state_ff == led_i2c_pkg::ST_ADDR) ?
                                      led_i2c_pkg::ST_CMD : led_i2c_pkg::ST_WDATA;
                        sda_oe_ff  <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                    end
                end else if (state_ff == led_i2c_pkg::ST_RDATA) begin
                    sda_oe_ff  <= ~tx_ff[7];
                    tx_ff      <= {tx_ff[6:0], 1'b0};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // write path and clock stretch
    // ------------------------------------------------------------
    logic       push_req;
    logic       push_ff;
    logic [7:0] push_addr_ff;
    logic [7:0] push_data_ff;
    logic       push_cmd_ff;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [16:0] fifo_out_data;
    logic       scl_oe_ff;
    logic       nxt_scl_oe;

    // key locations are read only, data aimed at them never leaves
    assign push_req = byte_end & ~start_ev & ~stop_ev &
                      ((state_ff == led_i2c_pkg::ST_CMD) ||
                       (state_ff == led_i2c_pkg::ST_WDATA && !is_key(ptr_ff)));
    // scl is low while a push waits, so holding it low costs the master only time
    assign nxt_scl_oe = push_req | (push_ff & ~fifo_in_ready);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            push_ff      <= 1'b0;
            push_addr_ff <= 8'h00;
            push_data_ff <= 8'h00;
            push_cmd_ff  <= 1'b0;
            scl_oe_ff    <= 1'b0;
        end else begin
            scl_oe_ff <= nxt_scl_oe;
            if (push_req) begin
                push_ff      <= 1'b1;
                push_cmd_ff  <= (state_ff == led_i2c_pkg::ST_CMD);
                push_addr_ff <= (state_ff == led_i2c_pkg::ST_CMD) ? shift_ff : ptr_ff;
                push_data_ff <= (state_ff == led_i2c_pkg::ST_CMD) ? 8'h00 : shift_ff;
            end else if (push_ff && fifo_in_ready) begin
                push_ff <= 1'b0;
            end
        end
    end

    wr_fifo #(
        .WIDTH (led_i2c_pkg::WR_WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push_ff),
        .in_ready  (fifo_in_ready),
        .in_data   ({push_cmd_ff, push_addr_ff, push_data_ff}),
        .out_valid (fifo_out_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign scl_o                  = 1'b0;
    assign sda_o                  = 1'b0;
    assign scl_oe                 = scl_oe_ff;
    assign sda_oe                 = sda_oe_ff;
    assign register_pointer_value = ptr_ff;
    assign bus_busy               = busy_ff;
    assign key_read_done          = key_done_ff;
    assign wr_valid               = fifo_out_valid;
    assign wr_cmd                 = fifo_out_data[16];
    assign wr_addr                = fifo_out_data[15:8];
    assign wr_data                = fifo_out_data[7:0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence addr_byte_seen;
        byte_end && state_ff == led_i2c_pkg::ST_ADDR && !start_ev && !stop_ev;
    endsequence

    sequence read_ack_clock;
        scl_rise && ack_phase_ff && state_ff == led_i2c_pkg::ST_RDATA && !start_ev && !stop_ev;
    endsequence

    chk_start_addr: assert property (start_ev |=> state_ff == led_i2c_pkg::ST_ADDR && busy_ff)
        else $error("start did not open address phase");
    chk_stop_idle: assert property (stop_ev |=> !busy_ff ##1 !busy_ff [*3] or start_ev)
        else $error("bus still busy after stop");
    chk_addr_ack: assert property (addr_byte_seen and addr_match |=> sda_oe_ff && ack_phase_ff)
        else $error("matching address not acknowledged");
    chk_addr_miss: assert property (addr_byte_seen and !addr_match
                                    |=> !sda_oe_ff && state_ff == led_i2c_pkg::ST_IGNORE)
        else $error("foreign address answered");
    chk_sda_stable: assert property ($changed(sda_oe_ff) |-> !$past(scl_s) || $past(start_ev || stop_ev))
        else $error("sda moved while scl high");
    chk_disp_wrap: assert property (read_ack_clock and ptr_ff == led_i2c_pkg::DISP_LAST
                                    and !sda_s |=> ptr_ff == led_i2c_pkg::DISP_FIRST)
        else $error("display pointer did not wrap");
    chk_key_wrap: assert property (read_ack_clock and ptr_ff == led_i2c_pkg::KEY_LAST
                                   and !sda_s |=> ptr_ff == led_i2c_pkg::KEY_FIRST && key_done_ff)
        else $error("key pointer did not wrap");
    chk_nack_hold: assert property (read_ack_clock and sda_s
                                    |=> $stable(ptr_ff) && state_ff == led_i2c_pkg::ST_IGNORE)
        else $error("pointer moved on not-acknowledge");
    // a stalled earlier push holds scl low, so no data byte can end while push_ff stands
    chk_key_drop: assert property (byte_end && state_ff == led_i2c_pkg::ST_WDATA
                                   && is_key(ptr_ff) && !start_ev && !stop_ev |=> !push_ff)
        else $error("write to key data pushed");
    chk_stretch_hold: assert property (push_ff && !fifo_in_ready |=> scl_oe_ff)
        else $error("full fifo did not hold scl");
endmodule : led_i2c_slave_port
`default_nettype wire

//--- core/led_i2c_pkg.sv
package led_i2c_pkg;
    // ------------------------------------------------------------
    // slave address and pointer map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FIXED   = 4'he;   // fixed upper nibble 1110
    localparam logic [7:0] DISP_FIRST   = 8'h00;
    localparam logic [7:0] DISP_LAST    = 8'h0f;
    localparam logic [7:0] KEY_FIRST    = 8'h40;
    localparam logic [7:0] KEY_LAST     = 8'h45;
    localparam logic [7:0] PTR_RESET    = 8'h00;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam int         WR_FIFO_DEPTH = 8;
    localparam int         WR_WORD_BITS  = 17;    // {cmd flag, addr, data}

    // ------------------------------------------------------------
    // serial engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } port_state_t;
endpackage : led_i2c_pkg

//--- core/wr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// small synchronous fifo, first word falls through
// ------------------------------------------------------------
module wr_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    // storage has no reset, only the pointers and the count need one
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + AW'(1);
            end
            if (do_pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + AW'(1);
            end
            count_ff <= count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : wr_fifo
`default_nettype wire

//--- bench/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// behavioural bus master, open drain: pulls low or releases only
// ------------------------------------------------------------
module i2c_master_model (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low
);
    // both lines released at power-up, pull-ups make the bus idle
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // release scl and wait while the slave stretches it, bounded so a stuck line shows
    task automatic scl_release;
        int n;
        n = 0;
        scl_low = 1'b0;
        while (scl_line !== 1'b1 && n < 4000) begin
            #50;
            n++;
        end
    endtask : scl_release
    // start or repeated start; scl low means a frame is still open
    task automatic start_cond;
        if (scl_low) begin
            #100;
            sda_low = 1'b0;
            #100;
            scl_release();
            #200;
        end
        sda_low = 1'b1;
        #200;
        scl_low = 1'b1;
    endtask : start_cond
    task automatic stop_cond;
        #100;
        sda_low = 1'b1;
        #100;
        scl_release();
        #200;
        sda_low = 1'b0;
        #400;
    endtask : stop_cond
    // 400 ns bit: 200 ns low with data moved halfway, then 200 ns high
    task automatic bit_out(input logic b);
        #100;
        sda_low = !b;
        #100;
        scl_release();
        #200;
        scl_low = 1'b1;
    endtask : bit_out
    task automatic bit_in(output logic b);
        #100;
        sda_low = 1'b0;
        #100;
        scl_release();
        #100;
        b = sda_line;
        #100;
        scl_low = 1'b1;
    endtask : bit_in
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = !b;
    endtask : write_byte
    // a released ninth bit is the not-acknowledge that ends a read
    task automatic read_byte(output logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(!ack);
    endtask : read_byte
endmodule : i2c_master_model
`default_nettype wire

//--- bench/led_driver_i2c_slave_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module led_driver_i2c_slave_port_tb;
    logic clk, rst_n, wr_ready, m_scl, m_sda, scl_oe, sda_oe, scl_o, sda_o, bus_busy;
    logic key_read_done, wr_valid, wr_cmd, ack;
    logic [2:0] strap;
    logic [7:0] ptr, wr_addr, wr_data, rd;
    logic [16:0] got_q[$];
    int bad_count, compares, kcnt, run, maxrun;
    wire scl_w = (scl_oe ? scl_o : 1'b1) & !m_scl;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & !m_sda;
    // read data stands in for the core's memory, known function of the pointer
    wire [7:0] rd_data = ptr ^ 8'h5a;
    led_i2c_slave_port u_led_i2c_slave_port (.clk(clk), .rst_n(rst_n), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]), .addr_strap_bit0(strap[0]),
        .rd_data(rd_data), .register_pointer_value(ptr), .bus_busy(bus_busy),
        .key_read_done(key_read_done), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_cmd(wr_cmd), .wr_addr(wr_addr), .wr_data(wr_data));
    i2c_master_model u_i2c_master_model (.scl_line(scl_w), .sda_line(sda_w),
        .scl_low(m_scl), .sda_low(m_sda));
    // ------------------------------------------------------------
    // clock, consumer of the write fifo, monitors
    // ------------------------------------------------------------
    initial clk = 1'b0;
    always #25 clk = ~clk;
    // stretch length is tracked so a stall can be told from the per-byte pulse
    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back({wr_cmd, wr_addr, wr_data});
        if (key_read_done === 1'b1) kcnt++;
        run = (scl_oe === 1'b1) ? run + 1 : 0;
        if (run > maxrun) maxrun = run;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] b, input logic exp_ack);
        u_i2c_master_model.write_byte(b, ack);
        chk({16'h0, ack}, {16'h0, exp_ack});
    endtask : send
    task automatic fetch(input logic [7:0] exp, input logic m_ack);
        u_i2c_master_model.read_byte(rd, m_ack);
        chk({9'h0, rd}, {9'h0, exp});
    endtask : fetch
    task automatic exp_entry(input logic [16:0] exp);
        chk((got_q.size() > 0) ? got_q.pop_front() : 17'h1ffff, exp);
    endtask : exp_entry
    function automatic logic [7:0] dev(input logic rw);
        return {led_i2c_pkg::ADDR_FIXED, strap, rw};
    endfunction : dev
    // open a write frame and load the pointer through the command byte
    task automatic open_at(input logic [7:0] p);
        u_i2c_master_model.start_cond();
        send(dev(1'b0), 1'b1);
        send(p, 1'b1);
        exp_entry({1'b1, p, 8'h00});
    endtask : open_at
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_addr;
        @(negedge clk) strap = 3'h5;
        u_i2c_master_model.start_cond();
        send({led_i2c_pkg::ADDR_FIXED, 3'h2, 1'b0}, 1'b0);
        send(8'h33, 1'b0);
        u_i2c_master_model.stop_cond();
        chk(17'(got_q.size()), 17'h0);
        @(negedge clk) strap = 3'h2;
        open_at(8'h03);
        chk({16'h0, bus_busy}, 17'h1);
        u_i2c_master_model.stop_cond();
        chk({16'h0, bus_busy}, 17'h0);
        chk({9'h0, ptr}, 17'h03);
        $display("t_addr done");
    endtask : t_addr
    task automatic t_write_wrap;
        open_at(8'h0e);
        for (int i = 0; i < 3; i++) send(8'ha0 + 8'(i), 1'b1);
        u_i2c_master_model.stop_cond();
        exp_entry({1'b0, 8'h0e, 8'ha0});
        exp_entry({1'b0, 8'h0f, 8'ha1});
        exp_entry({1'b0, 8'h00, 8'ha2});
        chk({9'h0, ptr}, 17'h01);
        $display("t_write_wrap done");
    endtask : t_write_wrap
    task automatic t_key_write;
        open_at(8'h44);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        u_i2c_master_model.stop_cond();
        chk(17'(got_q.size()), 17'h0);
        chk({9'h0, ptr}, 17'h40);
        chk(17'(kcnt), 17'h0);
        $display("t_key_write done");
    endtask : t_key_write
    // read across the display wrap; nack must not move the pointer
    task automatic t_read;
        open_at(8'h0f);
        u_i2c_master_model.start_cond();
        send(dev(1'b1), 1'b1);
        fetch(8'h0f ^ 8'h5a, 1'b1);
        fetch(8'h00 ^ 8'h5a, 1'b1);
        fetch(8'h01 ^ 8'h5a, 1'b0);
        u_i2c_master_model.stop_cond();
        chk({9'h0, ptr}, 17'h01);
        $display("t_read done");
    endtask : t_read
    task automatic t_key_read;
        open_at(8'h40);
        u_i2c_master_model.start_cond();
        send(dev(1'b1), 1'b1);
        for (int i = 0; i < 6; i++) fetch((8'h40 + 8'(i)) ^ 8'h5a, 1'b1);
        fetch(8'h40 ^ 8'h5a, 1'b0);
        u_i2c_master_model.stop_cond();
        chk(17'(kcnt), 17'h1);
        chk({9'h0, ptr}, 17'h40);
        $display("t_key_read done");
    endtask : t_key_read
    // consumer stalls for 100 us, long enough for the fifo to refuse and the clock to be stretched
    task automatic t_stall;
        @(negedge clk) wr_ready = 1'b0;
        maxrun = 0;
        fork
            begin
                // command entry is checked after the stall, the fifo holds it now while the consumer stalls
                u_i2c_master_model.start_cond();
                send(dev(1'b0), 1'b1);
                send(8'h00, 1'b1);
                for (int i = 0; i < 9; i++) send(8'hc0 + 8'(i), 1'b1);
                u_i2c_master_model.stop_cond();
            end
            begin
                #100000;
                @(negedge clk) wr_ready = 1'b1;
            end
        join
        chk({16'h0, maxrun > 100}, 17'h1);
        exp_entry({1'b1, 8'h00, 8'h00});
        for (int i = 0; i < 9; i++) exp_entry({1'b0, 8'(i), 8'hc0 + 8'(i)});
        $display("t_stall done");
    endtask : t_stall
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        wr_ready = 1'b1;
        strap = 3'h2;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_addr();
        t_write_wrap();
        t_key_write();
        t_read();
        t_key_read();
        t_stall();
        give_verdict();
    end
    // the whole run takes well under a millisecond of bus time
    initial begin
        #2000000;
        bad_count++;
        give_verdict();
    end
endmodule : led_driver_i2c_slave_port_tb
`default_nettype wire
